/* lfsm_pkg.sv */
// Notes on behaviour
// - flags bit 1 reads one, writes dropped
// - flags bits 3,5,15 read zero, ignore writes
// - flags never steer native instruction execution
// - arithmetic flags at fixed documented bit positions
// - system flags at fixed documented bit positions
// - arithmetic flags serve legacy ops only, native ignores
// - flags keep cumulative legacy results across switches
// - legacy stack lives in physical regs 8-15, 80-bit
// - legacy slot N maps to 8+((top+N) mod 8)
// - native access to 8-15 ignores top pointer
// - top pointer is a field of fp control
// - fp control register is 64 bits wide
// - fp status register is 64 bits wide
// - 64-bit instruction pointer: opcode, selector, address
// - 48-bit data pointer: selector and operand address
// - fault code is selector for descriptor tables, else zero
package lfsm_pkg;
  // register word indices on the bus (word address)
  localparam logic [3:0] LFSM_IDX_FLAGS_LO = 4'h0;
  localparam logic [3:0] LFSM_IDX_FLAGS_HI = 4'h1;
  localparam logic [3:0] LFSM_IDX_FCTL_LO = 4'h2;
  localparam logic [3:0] LFSM_IDX_FCTL_HI = 4'h3;
  localparam logic [3:0] LFSM_IDX_FSTS_LO = 4'h4;
  localparam logic [3:0] LFSM_IDX_FSTS_HI = 4'h5;
  localparam logic [3:0] LFSM_IDX_FIP_LO = 4'h6;
  localparam logic [3:0] LFSM_IDX_FIP_HI = 4'h7;
  localparam logic [3:0] LFSM_IDX_FDP_LO = 4'h8;
  localparam logic [3:0] LFSM_IDX_FDP_HI = 4'h9;
  localparam logic [3:0] LFSM_IDX_FPR_SEL = 4'hA;
  localparam logic [3:0] LFSM_IDX_FPR_D0 = 4'hB;
  localparam logic [3:0] LFSM_IDX_FPR_D1 = 4'hC;
  localparam logic [3:0] LFSM_IDX_FPR_D2 = 4'hD;
  localparam logic [3:0] LFSM_IDX_FAULT = 4'hE;
  // flag layout
  localparam int LFSM_B_CARRY = 0;
  localparam int LFSM_B_ONE = 1;
  localparam int LFSM_B_PARITY = 2;
  localparam int LFSM_B_AUX = 4;
  localparam int LFSM_B_ZERO = 6;
  localparam int LFSM_B_SIGN = 7;
  localparam int LFSM_B_TRAP = 8;
  localparam int LFSM_B_IEN = 9;
  localparam int LFSM_B_DIR = 10;
  localparam int LFSM_B_OVF = 11;
  localparam int LFSM_B_IOPL_LO = 12;
  localparam int LFSM_B_NEST = 14;
  localparam int LFSM_B_RESUME = 16;
  localparam int LFSM_B_V86 = 17;
  localparam int LFSM_B_ALIGN = 18;
  localparam int LFSM_B_VIF = 19;
  localparam int LFSM_B_VIP = 20;
  localparam int LFSM_B_PROBE = 21;
  // writable flag bits: 0,2,4,6..14,16..21; bit 1 forced one
  localparam logic [63:0] LFSM_FLAGS_WMASK = 64'h0000_0000_003F_7FD5;
  localparam logic [63:0] LFSM_FLAGS_FORCE1 = 64'h0000_0000_0000_0002;
  localparam logic [63:0] LFSM_FLAGS_RESET = 64'h0000_0000_0000_0002;
  localparam logic [63:0] LFSM_FCTL_RESET = 64'h0000_0000_0000_0000;
  // top pointer field in fp control
  localparam int LFSM_TOP_LO = 11;
  localparam int LFSM_FPR_W = 80;
  localparam int LFSM_FDP_W = 48;
  localparam logic [3:0] LFSM_FPR_BASE = 4'h8;
endpackage : lfsm_pkg

/* lfsm_core.sv */
`timescale 1ns/100ps
module lfsm_core (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [1:0] AVS_RESPONSE,
  input wire logic LEGACY_MODE,
  input wire logic FLAGS_UPD,
  input wire logic [63:0] FLAGS_IN,
  input wire logic FPR_WR,
  input wire logic FPR_LEGACY,
  input wire logic [2:0] FPR_IDX,
  input wire logic [79:0] FPR_WDATA,
  input wire logic [2:0] FPR_RIDX,
  input wire logic FPR_RLEGACY,
  output logic [79:0] FPR_RDATA,
  output logic [3:0] FPR_RPHYS,
  output logic [63:0] LEGACY_FLAGS_OUT,
  input wire logic FAULT_VALID,
  input wire logic FAULT_DESC_TBL,
  input wire logic [15:0] FAULT_SELECTOR,
  output logic [15:0] FAULT_CODE
);
  import lfsm_pkg::*;

  logic [63:0] flags_ff; // stored writable flag bits; reset also loads bit 1
  logic [63:0] fctl_ff; // fp control, holds top pointer
  logic [63:0] fsts_ff; // fp status and tag
  logic [63:0] fip_ff; // opcode, code selector, address
  logic [LFSM_FDP_W-1:0] fdp_ff; // data selector and operand address
  logic [LFSM_FPR_W-1:0] fpr_ff [0:7]; // physical regs 8..15
  logic [2:0] sel_ff; // bus window onto physical reg 8+sel
  logic ack_ff; // one wait cycle then answer
  logic [63:0] flags_view; // what any reader sees
  logic [2:0] top_ptr;
  logic [2:0] wr_phys;
  logic [2:0] rd_phys;
  logic [31:0] rmux;
  logic hit;
  logic [31:0] bmask;

  // view applies fixed ones, zeros and reserved zeros
  assign flags_view = (flags_ff & LFSM_FLAGS_WMASK) | LFSM_FLAGS_FORCE1;
  assign top_ptr = fctl_ff[LFSM_TOP_LO +: 3];
  // legacy index rotates by top, mod 8 via 3-bit wrap
  assign wr_phys = FPR_LEGACY ? 3'(top_ptr + FPR_IDX) : FPR_IDX;
  assign rd_phys = FPR_RLEGACY ? 3'(top_ptr + FPR_RIDX) : FPR_RIDX;

  // byte-lane mask from byteenable
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_be
      assign bmask[g*8 +: 8] = {8{AVS_BYTEENABLE[g]}};
    end
  endgenerate

  // access completes on the cycle after it is first seen
  wire do_wr = AVS_WRITE & ack_ff;
  wire bus_fpr = do_wr & (AVS_ADDRESS >= LFSM_IDX_FPR_D0) & (AVS_ADDRESS <= LFSM_IDX_FPR_D2);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // handshake: waitrequest high one cycle, then low for the answer
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (AVS_READ | AVS_WRITE) & ~ack_ff;
    end
  end

  // legacy flags: only legacy ops or software update, value persists
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      flags_ff <= LFSM_FLAGS_RESET;
    end else if (FLAGS_UPD && LEGACY_MODE) begin
      // native side never writes these, so they hold legacy results
      flags_ff <= FLAGS_IN & LFSM_FLAGS_WMASK;
    end else if (do_wr && AVS_ADDRESS == LFSM_IDX_FLAGS_LO) begin
      flags_ff[31:0] <= merge(flags_ff[31:0], AVS_WRITEDATA, bmask) & LFSM_FLAGS_WMASK[31:0];
    end
  end

  // fp control and status, 64 bits each
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      fctl_ff <= LFSM_FCTL_RESET;
      fsts_ff <= '0;
    end else if (do_wr) begin
      unique case (AVS_ADDRESS)
        LFSM_IDX_FCTL_LO: fctl_ff[31:0] <= merge(fctl_ff[31:0], AVS_WRITEDATA, bmask);
        LFSM_IDX_FCTL_HI: fctl_ff[63:32] <= merge(fctl_ff[63:32], AVS_WRITEDATA, bmask);
        LFSM_IDX_FSTS_LO: fsts_ff[31:0] <= merge(fsts_ff[31:0], AVS_WRITEDATA, bmask);
        LFSM_IDX_FSTS_HI: fsts_ff[63:32] <= merge(fsts_ff[63:32], AVS_WRITEDATA, bmask);
        default: ;
      endcase
    end
  end

  // instruction and data pointers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      fip_ff <= '0;
      fdp_ff <= '0;
    end else if (do_wr) begin
      unique case (AVS_ADDRESS)
        LFSM_IDX_FIP_LO: fip_ff[31:0] <= merge(fip_ff[31:0], AVS_WRITEDATA, bmask);
        LFSM_IDX_FIP_HI: fip_ff[63:32] <= merge(fip_ff[63:32], AVS_WRITEDATA, bmask);
        LFSM_IDX_FDP_LO: fdp_ff[31:0] <= merge(fdp_ff[31:0], AVS_WRITEDATA, bmask);
        LFSM_IDX_FDP_HI: fdp_ff[47:32] <= 16'(merge({16'h0000, fdp_ff[47:32]}, AVS_WRITEDATA, bmask));
        default: ;
      endcase
    end
  end

  // bus window select onto a physical stack register
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sel_ff <= 3'h0;
    end else if (do_wr && AVS_ADDRESS == LFSM_IDX_FPR_SEL && AVS_BYTEENABLE[0]) begin
      sel_ff <= AVS_WRITEDATA[2:0];
    end
  end

  // physical register file; core port wins over the bus window
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 8; i++) fpr_ff[i] <= '0;
    end else if (FPR_WR) begin
      fpr_ff[wr_phys] <= FPR_WDATA;
    end else if (bus_fpr) begin
      // bus window is native style: physical, no rotation
      unique case (AVS_ADDRESS)
        LFSM_IDX_FPR_D0: fpr_ff[sel_ff][31:0] <= merge(fpr_ff[sel_ff][31:0], AVS_WRITEDATA, bmask);
        LFSM_IDX_FPR_D1: fpr_ff[sel_ff][63:32] <= merge(fpr_ff[sel_ff][63:32], AVS_WRITEDATA, bmask);
        default: fpr_ff[sel_ff][79:64] <= 16'(merge({16'h0000, fpr_ff[sel_ff][79:64]}, AVS_WRITEDATA, bmask));
      endcase
    end
  end

  // core read port, registered
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      FPR_RDATA <= '0;
      FPR_RPHYS <= LFSM_FPR_BASE;
    end else begin
      FPR_RDATA <= fpr_ff[rd_phys];
      FPR_RPHYS <= LFSM_FPR_BASE + {1'b0, rd_phys};
    end
  end

  // fault error code: selector only for descriptor tables
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      FAULT_CODE <= 16'h0000;
    end else if (FAULT_VALID) begin
      FAULT_CODE <= FAULT_DESC_TBL ? FAULT_SELECTOR : 16'h0000;
    end
  end

  // flags mirror for legacy consumers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      LEGACY_FLAGS_OUT <= LFSM_FLAGS_RESET;
    end else begin
      LEGACY_FLAGS_OUT <= flags_view;
    end
  end

  // read mux
  always_comb begin
    hit = 1'b1;
    rmux = 32'h0000_0000;
    unique case (AVS_ADDRESS)
      LFSM_IDX_FLAGS_LO: rmux = flags_view[31:0];
      LFSM_IDX_FLAGS_HI: rmux = flags_view[63:32];
      LFSM_IDX_FCTL_LO: rmux = fctl_ff[31:0];
      LFSM_IDX_FCTL_HI: rmux = fctl_ff[63:32];
      LFSM_IDX_FSTS_LO: rmux = fsts_ff[31:0];
      LFSM_IDX_FSTS_HI: rmux = fsts_ff[63:32];
      LFSM_IDX_FIP_LO: rmux = fip_ff[31:0];
      LFSM_IDX_FIP_HI: rmux = fip_ff[63:32];
      LFSM_IDX_FDP_LO: rmux = fdp_ff[31:0];
      LFSM_IDX_FDP_HI: rmux = {16'h0000, fdp_ff[47:32]};
      LFSM_IDX_FPR_SEL: rmux = {29'h0000_0000, sel_ff};
      LFSM_IDX_FPR_D0: rmux = fpr_ff[sel_ff][31:0];
      LFSM_IDX_FPR_D1: rmux = fpr_ff[sel_ff][63:32];
      LFSM_IDX_FPR_D2: rmux = {16'h0000, fpr_ff[sel_ff][79:64]};
      LFSM_IDX_FAULT: rmux = {16'h0000, FAULT_CODE};
      default: hit = 1'b0; // unmapped: zero data, decode error
    endcase
  end

  // registered answer; waitrequest low exactly in the ack cycle
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      AVS_READDATA <= 32'h0000_0000;
      AVS_WAITREQUEST <= 1'b1;
      AVS_RESPONSE <= 2'b00;
    end else begin
      AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & ~ack_ff);
      AVS_READDATA <= AVS_READ ? rmux : 32'h0000_0000;
      AVS_RESPONSE <= hit ? 2'b00 : 2'b11;
    end
  end
endmodule : lfsm_core

/* lfsm_checker_properties.sv */
`timescale 1ns/100ps
module lfsm_checker (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic AVS_WRITE,
  input wire logic LEGACY_MODE,
  input wire logic FLAGS_UPD,
  input wire logic [2:0] FPR_RIDX,
  input wire logic FPR_RLEGACY,
  input wire logic [3:0] FPR_RPHYS,
  input wire logic [63:0] LEGACY_FLAGS_OUT,
  input wire logic FAULT_VALID,
  input wire logic FAULT_DESC_TBL,
  input wire logic [15:0] FAULT_SELECTOR,
  input wire logic [15:0] FAULT_CODE
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // no write source for two edges: covers a two-stage flags view as well
  sequence quiet_s;
    (!AVS_WRITE && !(LEGACY_MODE && FLAGS_UPD)) [*2];
  endsequence
  AST_FLAGS_ONE: assert property (LEGACY_FLAGS_OUT[1] == 1'b1)
    else $error("flags bit 1 not one");
  AST_FLAGS_ZERO: assert property (!LEGACY_FLAGS_OUT[3] && !LEGACY_FLAGS_OUT[5] && !LEGACY_FLAGS_OUT[15])
    else $error("ignored flags bit set");
  AST_FLAGS_RSVD: assert property (LEGACY_FLAGS_OUT[63:22] == 42'h0)
    else $error("reserved flags bits set");
  AST_FLAGS_HOLD: assert property (quiet_s |=> $stable(LEGACY_FLAGS_OUT))
    else $error("flags moved without a legacy update");
  AST_RPHYS_BANK: assert property (FPR_RPHYS[3] == 1'b1)
    else $error("physical index outside 8..15");
  AST_NATIVE_PHYS: assert property (!FPR_RLEGACY |=> FPR_RPHYS == {1'b1, $past(FPR_RIDX)})
    else $error("native read was rotated");
  AST_FAULT_SEL: assert property (FAULT_VALID && FAULT_DESC_TBL |=> FAULT_CODE == $past(FAULT_SELECTOR))
    else $error("table fault code not the selector");
  AST_FAULT_ZERO: assert property (FAULT_VALID && !FAULT_DESC_TBL |=> FAULT_CODE == 16'h0000)
    else $error("other fault code not zero");
  COV_LEG_UPD: cover property (LEGACY_MODE && FLAGS_UPD);
  COV_LEG_READ: cover property (FPR_RLEGACY ##1 FPR_RPHYS != {1'b1, $past(FPR_RIDX)});
  COV_FAULT: cover property (FAULT_VALID && FAULT_DESC_TBL);
endmodule : lfsm_checker
bind lfsm_core lfsm_checker chk_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .AVS_WRITE(AVS_WRITE),
  .LEGACY_MODE(LEGACY_MODE), .FLAGS_UPD(FLAGS_UPD), .FPR_RIDX(FPR_RIDX), .FPR_RLEGACY(FPR_RLEGACY),
  .FPR_RPHYS(FPR_RPHYS), .LEGACY_FLAGS_OUT(LEGACY_FLAGS_OUT), .FAULT_VALID(FAULT_VALID),
  .FAULT_DESC_TBL(FAULT_DESC_TBL), .FAULT_SELECTOR(FAULT_SELECTOR), .FAULT_CODE(FAULT_CODE));

/* legacy_flags_fp_stack_map_bench.sv */
`timescale 1ns/100ps
module legacy_flags_fp_stack_map_bench;
  import lfsm_pkg::*;
  logic CLK_SYS, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, LEGACY_MODE, FLAGS_UPD;
  logic FPR_WR, FPR_LEGACY, FPR_RLEGACY, FAULT_VALID, FAULT_DESC_TBL;
  logic [3:0] AVS_ADDRESS, FPR_RPHYS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic [1:0] AVS_RESPONSE, rr;
  logic [63:0] FLAGS_IN, LEGACY_FLAGS_OUT;
  logic [2:0] FPR_IDX, FPR_RIDX;
  logic [79:0] FPR_WDATA, FPR_RDATA;
  logic [15:0] FAULT_SELECTOR, FAULT_CODE;
  int n_mismatch = 0;
  int checks = 0;
  lfsm_core dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE), .LEGACY_MODE(LEGACY_MODE),
    .FLAGS_UPD(FLAGS_UPD), .FLAGS_IN(FLAGS_IN), .FPR_WR(FPR_WR), .FPR_LEGACY(FPR_LEGACY), .FPR_IDX(FPR_IDX),
    .FPR_WDATA(FPR_WDATA), .FPR_RIDX(FPR_RIDX), .FPR_RLEGACY(FPR_RLEGACY), .FPR_RDATA(FPR_RDATA),
    .FPR_RPHYS(FPR_RPHYS), .LEGACY_FLAGS_OUT(LEGACY_FLAGS_OUT), .FAULT_VALID(FAULT_VALID),
    .FAULT_DESC_TBL(FAULT_DESC_TBL), .FAULT_SELECTOR(FAULT_SELECTOR), .FAULT_CODE(FAULT_CODE));
  // free-running 100 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // x must match exactly; an x against 0 or 1 never passes
  task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one bus cycle; request held until waitrequest is sampled low, bounded wait
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
    rd = AVS_READDATA;
    rr = AVS_RESPONSE;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (n >= 40) n_mismatch++;
  endtask : bus
  task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask : rdc
  // one core flag result pulse, then let a two-stage view settle
  task automatic upd(input logic m, input logic [63:0] v);
    @(posedge CLK_SYS);
    LEGACY_MODE <= m;
    FLAGS_IN <= v;
    FLAGS_UPD <= 1'b1;
    @(posedge CLK_SYS);
    FLAGS_UPD <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1;
  endtask : upd
  task automatic fwr(input logic l, input logic [2:0] i, input logic [79:0] d);
    @(posedge CLK_SYS);
    FPR_WR <= 1'b1;
    FPR_LEGACY <= l;
    FPR_IDX <= i;
    FPR_WDATA <= d;
    @(posedge CLK_SYS);
    FPR_WR <= 1'b0;
  endtask : fwr
  task automatic frd(input logic l, input logic [2:0] i);
    @(posedge CLK_SYS);
    FPR_RLEGACY <= l;
    FPR_RIDX <= i;
    @(posedge CLK_SYS);
    #1;
  endtask : frd
  task automatic t_flags();
    chk("flags_out_reset", LEGACY_FLAGS_OUT, 64'h0000_0000_0000_0002);
    bus(1'b1, LFSM_IDX_FLAGS_LO, 32'hFFFF_FFFF);
    rdc("flags_lo_ones", LFSM_IDX_FLAGS_LO, 32'h003F_7FD7);
    bus(1'b1, LFSM_IDX_FLAGS_HI, 32'hFFFF_FFFF);
    rdc("flags_hi", LFSM_IDX_FLAGS_HI, 32'h0000_0000);
    bus(1'b1, LFSM_IDX_FLAGS_LO, 32'h0000_8028);
    rdc("flags_lo_ignored", LFSM_IDX_FLAGS_LO, 32'h0000_0002);
    // well-behaved software write: ignored and reserved bits left zero
    bus(1'b1, LFSM_IDX_FLAGS_LO, 32'h0000_0001);
    rdc("flags_lo_clean", LFSM_IDX_FLAGS_LO, 32'h0000_0003);
    chk("flags_resp_ok", rr, 2'b00);
    upd(1'b1, 64'hFFFF_FFFF_FFFF_FFFF);
    chk("flags_legacy_upd", LEGACY_FLAGS_OUT, 64'h0000_0000_003F_7FD7);
    // native results must not disturb what legacy code left behind
    upd(1'b0, 64'h0000_0000_0000_0000);
    chk("flags_native_upd", LEGACY_FLAGS_OUT, 64'h0000_0000_003F_7FD7);
    $display("test flags done");
  endtask : t_flags
  task automatic t_regs();
    for (int i = 2; i <= 9; i++) bus(1'b1, i[3:0], {16'hC3C3, 12'h000, i[3:0]});
    // data pointer high word keeps only 16 bits, 48 in all
    for (int i = 2; i <= 9; i++) rdc("fp_reg", i[3:0], {(i == 9) ? 16'h0000 : 16'hC3C3, 12'h000, i[3:0]});
    rdc("unmapped_data", 4'hF, 32'h0000_0000);
    chk("unmapped_resp", rr, 2'b11);
    $display("test regs done");
  endtask : t_regs
  task automatic t_stack();
    bus(1'b1, LFSM_IDX_FCTL_LO, 32'h0000_1800);
    for (int i = 0; i < 8; i++) fwr(1'b0, i[2:0], {8'hA5, 69'h0, i[2:0]});
    for (int n = 0; n < 8; n++) begin
      frd(1'b1, n[2:0]);
      chk("leg_phys", FPR_RPHYS, {1'b1, n[2:0] + 3'h3});
      chk("leg_data", FPR_RDATA, {8'hA5, 69'h0, n[2:0] + 3'h3});
      frd(1'b0, n[2:0]);
      chk("nat_data", FPR_RDATA, {8'hA5, 69'h0, n[2:0]});
    end
    // slot 5 with top 3 wraps round to physical 8
    fwr(1'b1, 3'h5, 80'h1234_0000_0000_0000_5678);
    frd(1'b0, 3'h0);
    chk("leg_wr_wrap", FPR_RDATA, 80'h1234_0000_0000_0000_5678);
    bus(1'b1, LFSM_IDX_FPR_SEL, 32'h0000_0000);
    rdc("win_sel", LFSM_IDX_FPR_SEL, 32'h0000_0000);
    // native window shows physical 8, not logical slot zero
    rdc("win_d0", LFSM_IDX_FPR_D0, 32'h0000_5678);
    rdc("win_d2", LFSM_IDX_FPR_D2, 32'h0000_1234);
    $display("test stack done");
  endtask : t_stack
  task automatic t_fault(input logic t, input logic [15:0] s, input logic [15:0] exp);
    @(posedge CLK_SYS);
    FAULT_VALID <= 1'b1;
    FAULT_DESC_TBL <= t;
    FAULT_SELECTOR <= s;
    @(posedge CLK_SYS);
    FAULT_VALID <= 1'b0;
    #1;
    chk("fault_code", FAULT_CODE, exp);
    rdc("fault_reg", LFSM_IDX_FAULT, {16'h0000, exp});
    $display("test fault done");
  endtask : t_fault
  // all inputs defined at time zero, reset for eight cycles
  initial begin
    {AVS_READ, AVS_WRITE, LEGACY_MODE, FLAGS_UPD, FPR_WR, FPR_LEGACY, FPR_RLEGACY} = '0;
    {FAULT_VALID, FAULT_DESC_TBL, AVS_ADDRESS, AVS_WRITEDATA, FLAGS_IN} = '0;
    {FPR_IDX, FPR_RIDX, FPR_WDATA, FAULT_SELECTOR} = '0;
    RST_N = 1'b0;
    repeat (8) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    #1;
    t_flags();
    t_regs();
    t_stack();
    t_fault(1'b1, 16'h1234, 16'h1234);
    t_fault(1'b0, 16'h5678, 16'h0000);
    summarize();
  end
  // run needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    summarize();
  end
endmodule : legacy_flags_fp_stack_map_bench
